// >>> crst_seq.sv
// crst_seq: processor reset sequencer, start-up path select and bus cycle framing
// assumes: reset_in is the board reset (high active level, asynchronous),
// hold/flush/test-select and ready inputs are synchronous to clock
//
// Behaviour
// - address-hold high before reset falls selects self test
// - self test about 2**20 clocks, no cycles
// - test control, microcode, tlb and cache
// - result in accumulator, zero means pass
// - normal start: first cycle 217 clocks later
// - flush low before reset falls enters float test
// - float bus outputs and four status outputs
// - stay floated until reset rises again
// - reset taken asynchronously
// - hold still answered while in reset
// - strobe starts cycle, either ready ends it
// - every bus cycle lasts at least two clocks
// - 8, 16 or 32 bit, single or multiple, burst
`timescale 1ns/1ns
module crst_seq #(
  parameter int unsigned TEST_CYCLES = crst_pkg::SELF_TEST_CYCLES,  // self-test length
  parameter int unsigned START_DLY   = crst_pkg::FIRST_CYCLE_DLY    // normal start delay
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  nrst,
  // board reset and start-up selects
  input  wire logic                  reset_in,
  input  wire logic                  addr_hold_req,
  input  wire logic                  flush_n,
  // bus hold handshake
  input  wire logic                  hold_req,
  // cycle end from the board
  input  wire logic                  ready_n,
  input  wire logic                  burst_ready_n,
  // core request and status
  input  wire crst_pkg::crst_req_t   req,
  input  wire logic                  fp_fault,
  input  wire logic                  parity_fault,
  input  wire logic [3:0]            unit_fault,
  // bus outputs with enables
  output crst_pkg::crst_bus_t        bus_out,
  output logic                       bus_oe,
  output crst_pkg::crst_misc_t       misc_out,
  output logic                       misc_oe,
  // core status
  output logic                       req_done,
  output logic [31:0]                accumulator,
  output logic                       running
);

  logic              rst_s1_q;   // reset release synchroniser, first stage
  logic              rst_n_q;    // synchronised reset for the rest of the design
  logic              brd_s1_q;   // board reset sync, first stage
  logic              brd_q;      // board reset, synchronised
  logic [1:0]        sel_d1_q;   // select pins, first delay stage {hold, flush}
  logic [1:0]        sel_d2_q;   // select pins, lined up with brd_q
  logic              hold_sel_q; // address-hold seen at last reset-high edge
  logic              flush_sel_q;// flush seen low at last reset-high edge
  crst_pkg::crst_state_t state_q;
  logic [31:0]       wait_q;     // start-up delay count
  logic              in_cyc_q;   // a bus cycle is open
  logic              first_q;    // first clock of the open cycle
  logic              st_start_q; // self-test kick
  logic              st_done;
  logic [31:0]       st_result;
  logic              cyc_end;

  // reset release through two flops; assertion is immediate
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // board reset synchroniser; second stage is the only reader of the first
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      brd_s1_q <= 1'b1;
      brd_q    <= 1'b1;
      sel_d1_q <= 2'h0;
      sel_d2_q <= 2'h0;
    end
    else
    begin
      brd_s1_q <= reset_in;
      brd_q    <= brd_s1_q;
      // pins ride the same two stages, else a late select would still count
      sel_d1_q <= {addr_hold_req, ~flush_n};
      sel_d2_q <= sel_d1_q;
    end
  end

  // selects track the pins while reset is high, so the last high edge wins
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      hold_sel_q  <= 1'b0;
      flush_sel_q <= 1'b0;
    end
    else if (brd_q)
    begin
      hold_sel_q  <= sel_d2_q[1];  // pin value at the last edge with reset high
      flush_sel_q <= sel_d2_q[0];
    end
  end

  // start-up state machine
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q    <= crst_pkg::CRST_RESET;
      wait_q     <= 32'h0000_0000;
      st_start_q <= 1'b0;
    end
    else
    begin
      st_start_q <= 1'b0;
      if (brd_q)
        state_q <= crst_pkg::CRST_RESET;  // reset overrides every state
      else
        unique case (state_q)
          crst_pkg::CRST_RESET:
          begin
            if (flush_sel_q)
              state_q <= crst_pkg::CRST_FLOAT;
            else if (hold_sel_q)
            begin
              state_q    <= crst_pkg::CRST_TEST;
              st_start_q <= 1'b1;
            end
            else
            begin
              state_q <= crst_pkg::CRST_WAIT;
              wait_q  <= 32'(START_DLY - 1);
            end
          end
          crst_pkg::CRST_TEST:
            if (st_done)
            begin
              state_q <= crst_pkg::CRST_WAIT;  // no cycles until done
              wait_q  <= 32'(START_DLY - 1);
            end
          crst_pkg::CRST_WAIT:
            if (wait_q == 32'h0000_0000)
              state_q <= crst_pkg::CRST_RUN;
            else
              wait_q <= wait_q - 32'h0000_0001;
          crst_pkg::CRST_RUN:   state_q <= crst_pkg::CRST_RUN;
          crst_pkg::CRST_FLOAT: state_q <= crst_pkg::CRST_FLOAT;  // held until reset
          default:              state_q <= crst_pkg::CRST_RESET;
        endcase
    end
  end

  // self-test engine
  crst_selftest #(
    .CYCLES     (TEST_CYCLES)
  ) u_selftest (
    .clock      (clock),
    .rst_n      (rst_n_q),
    .start      (st_start_q),
    .unit_fault (unit_fault),
    .done       (st_done),
    .result     (st_result)
  );

  // result lands in the accumulator
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      accumulator <= crst_pkg::RESULT_RESET;
    else if (st_done && state_q == crst_pkg::CRST_TEST)
      accumulator <= st_result;
  end

  // either ready closes the cycle, never on its first clock
  assign cyc_end = in_cyc_q && !first_q && (!ready_n || !burst_ready_n);

  // bus cycle framing; only in run state and without hold
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      in_cyc_q <= 1'b0;
      first_q  <= 1'b0;
      req_done <= 1'b0;
      bus_out  <= '{addr_strobe_n: 1'b1, addr: 32'h0000_0000, write: 1'b0,
                    size: crst_pkg::SIZE_32, burst_last_n: 1'b1};
    end
    else
    begin
      req_done              <= cyc_end;
      first_q               <= 1'b0;
      bus_out.addr_strobe_n <= 1'b1;
      if (brd_q)
        in_cyc_q <= 1'b0;  // reset abandons any open cycle
      else if (cyc_end)
        in_cyc_q <= 1'b0;  // held open until a ready
      else if (!in_cyc_q && req.valid && state_q == crst_pkg::CRST_RUN && !hold_req)
      begin
        in_cyc_q                 <= 1'b1;
        first_q                  <= 1'b1;  // first clock cannot end the cycle
        bus_out.addr_strobe_n    <= 1'b0;
        bus_out.addr             <= req.addr;
        bus_out.write            <= req.write;
        bus_out.size             <= req.size;  // 8/16/32
        bus_out.burst_last_n     <= ~(req.burst & req.multi);
      end
    end
  end

  // hold answered in every state, reset included
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      misc_out <= '{hold_ack: 1'b0, bus_request: 1'b0, fp_error_n: 1'b1, parity_check_n: 1'b1};
    end
    else
    begin
      misc_out.hold_ack       <= hold_req && !in_cyc_q;
      misc_out.bus_request    <= req.valid && !in_cyc_q;
      misc_out.fp_error_n     <= ~fp_fault;
      misc_out.parity_check_n <= ~parity_fault;
    end
  end

  // output enables: float-test drops all, hold drops the bus group
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      bus_oe  <= 1'b1;
      misc_oe <= 1'b1;
      running <= 1'b0;
    end
    else
    begin
      bus_oe  <= state_q != crst_pkg::CRST_FLOAT && !(hold_req && !in_cyc_q);
      misc_oe <= state_q != crst_pkg::CRST_FLOAT;
      running <= state_q == crst_pkg::CRST_RUN;
    end
  end

endmodule : crst_seq

// >>> crst_pkg.sv
// crst_pkg: shared constants and carrier types for the reset/test sequencer
// assumes: one 125 MHz clock, no software-visible registers
package crst_pkg;

  // start-up timing counts, in processor clocks
  localparam int unsigned SELF_TEST_CYCLES = 1048576;  // about 2**20 clocks of self test
  localparam int unsigned FIRST_CYCLE_DLY  = 217;      // clocks from reset release to first cycle
  localparam int unsigned MIN_BUS_CLOCKS   = 2;        // least clocks per bus cycle

  // self-test result reset value and pass code
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [31:0] RESULT_PASS  = 32'h0000_0000;

  // transfer size codes
  localparam logic [1:0] SIZE_8  = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;

  // start-up sequencer states, gray along reset -> test -> wait -> run
  typedef enum logic [2:0] {
    CRST_RESET = 3'h0,
    CRST_TEST  = 3'h1,
    CRST_WAIT  = 3'h3,
    CRST_RUN   = 3'h2,
    CRST_FLOAT = 3'h6
  } crst_state_t;

  // bus cycle request from the core side
  typedef struct packed {
    logic        valid;  // a cycle is wanted
    logic [31:0] addr;   // cycle address
    logic        write;  // write when high
    logic [1:0]  size;   // 8, 16 or 32 bits
    logic        burst;  // burst allowed
    logic        multi;  // part of a multiple-cycle transfer
  } crst_req_t;

  // bus control driven toward the board
  typedef struct packed {
    logic        addr_strobe_n;  // starts a cycle, low for one clock
    logic [31:0] addr;           // held through the cycle
    logic        write;          // direction
    logic [1:0]  size;           // transfer size
    logic        burst_last_n;   // low for a burst cycle that is part of a multiple-cycle transfer
  } crst_bus_t;

  // outputs that may be floated in test mode
  typedef struct packed {
    logic hold_ack;
    logic bus_request;
    logic fp_error_n;
    logic parity_check_n;
  } crst_misc_t;

endpackage : crst_pkg

// >>> crst_selftest.sv
// crst_selftest: self-test engine, walks four internal units in turn
// assumes: started by a one-cycle pulse, unit fault flags are synchronous levels
`timescale 1ns/1ns
module crst_selftest #(
  parameter int unsigned CYCLES = crst_pkg::SELF_TEST_CYCLES  // total test length
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // control
  input  wire logic        start,
  // unit fault flags: control logic, microcode rom, tlb, cache array
  input  wire logic [3:0]  unit_fault,
  // result
  output logic             done,
  output logic [31:0]      result
);

  localparam int unsigned QUARTER = CYCLES / 4;  // clocks spent on each unit

  logic        busy_q;      // test running
  logic [31:0] count_q;     // clocks left in the current unit
  logic [1:0]  unit_q;      // unit under test
  logic [3:0]  fail_q;      // failures seen so far

  // sequence the four units, each for a quarter of the run
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q  <= 1'b0;
      count_q <= 32'h0000_0000;
      unit_q  <= 2'h0;
      done    <= 1'b0;
    end
    else if (start)
    begin
      busy_q  <= 1'b1;
      count_q <= 32'(QUARTER - 1);
      unit_q  <= 2'h0;
      done    <= 1'b0;
    end
    else if (busy_q)
    begin
      if (count_q != 32'h0000_0000)
        count_q <= count_q - 32'h0000_0001;
      else if (unit_q == 2'h3)
      begin
        busy_q <= 1'b0;  // last unit finished
        done   <= 1'b1;
      end
      else
      begin
        unit_q  <= unit_q + 2'h1;  // next unit
        count_q <= 32'(QUARTER - 1);
      end
    end
    else
      done <= 1'b0;  // one-clock finish pulse, so a later run never sees a stale one
  end

  // collect failures of the unit under test
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fail_q <= 4'h0;
    else if (start)
      fail_q <= 4'h0;
    else if (busy_q)
      fail_q[unit_q] <= fail_q[unit_q] | unit_fault[unit_q];
  end

  // result word: zero on pass, fault bits otherwise
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      result <= crst_pkg::RESULT_RESET;
    else if (busy_q && count_q == 32'h0000_0000 && unit_q == 2'h3)
      result <= (fail_q == 4'h0) ? crst_pkg::RESULT_PASS : {28'h0000000, fail_q};
  end

endmodule : crst_selftest

// >>> crst_seq_assertions.sv
// crst_seq_assertions: port checker for the reset sequencer
// assumes: sees only crst_seq ports, one clock domain
`timescale 1ns/1ns
module crst_seq_assertions #(
  parameter int unsigned TEST_CYCLES = 64,  // self-test length
  parameter int unsigned START_DLY   = 217  // normal start delay
) (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 nrst,
  // board inputs
  input wire logic                 reset_in,
  input wire logic                 addr_hold_req,
  input wire logic                 flush_n,
  input wire logic                 hold_req,
  input wire logic                 ready_n,
  input wire logic                 burst_ready_n,
  // core inputs
  input wire crst_pkg::crst_req_t  req,
  input wire logic                 fp_fault,
  input wire logic                 parity_fault,
  input wire logic [3:0]           unit_fault,
  // outputs
  input wire crst_pkg::crst_bus_t  bus_out,
  input wire logic                 bus_oe,
  input wire crst_pkg::crst_misc_t misc_out,
  input wire logic                 misc_oe,
  input wire logic                 req_done,
  input wire logic [31:0]          accumulator,
  input wire logic                 running
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_strobe_pulse: assert property ($fell(bus_out.addr_strobe_n) |=> bus_out.addr_strobe_n)
    else $error("strobe longer than one clock");
  a_strobe_cause: assert property ($fell(bus_out.addr_strobe_n) |-> $past(req.valid))
    else $error("strobe without request");
  a_two_clocks: assert property (!bus_out.addr_strobe_n |=> !req_done)
    else $error("cycle shorter than two clocks");
  a_ready_cause: assert property (req_done |-> $past(!ready_n || !burst_ready_n))
    else $error("cycle ended without ready");
  a_run_only: assert property (!bus_out.addr_strobe_n |-> running)
    else $error("cycle outside run state");
  a_first_delay: assert property ($fell(reset_in) |=> !running [*8])
    else $error("run too soon after reset");
  a_float_all: assert property (!misc_oe |-> !bus_oe)
    else $error("bus driven in float mode");
  a_float_stays: assert property (!misc_oe && !reset_in |=> !misc_oe)
    else $error("float mode left early");
  a_hold_quiet: assert property (misc_out.hold_ack |-> bus_out.addr_strobe_n)
    else $error("strobe during hold");
  a_hold_reset: assert property ($rose(hold_req) && reset_in |-> ##[1:6] misc_out.hold_ack)
    else $error("hold ignored in reset");
  // main scenarios reached
  c_run: cover property ($rose(running));
  c_float: cover property ($fell(misc_oe));
  c_done: cover property (req_done);
endmodule : crst_seq_assertions

bind crst_seq crst_seq_assertions #(.TEST_CYCLES(TEST_CYCLES), .START_DLY(START_DLY))
  crst_seq_assertions_i (.*);

// >>> crst_board.sv
// crst_board: board ready logic, counts wait states per cycle
// assumes: ready lines pulled up when not asserted
`timescale 1ns/1ns
module crst_board (
  // clock
  input wire logic                clock,
  // bus from the processor
  input wire crst_pkg::crst_bus_t bus_out,
  // wait states and ready kind
  input wire logic [3:0]          waits,
  input wire logic                use_burst,
  // ready back to the processor
  output logic                    ready_n,
  output logic                    burst_ready_n
);
  int   cnt;     // wait states so far
  logic open_q;  // cycle seen, no ready yet
  initial
  begin
    ready_n = 1'b1;
    burst_ready_n = 1'b1;
    open_q = 1'b0;
  end
  // one-clock ready after the wait count; either kind ends it
  always @(posedge clock)
  begin
    ready_n <= 1'b1;
    burst_ready_n <= 1'b1;
    if (!bus_out.addr_strobe_n && waits == 4'h0)
    begin
      ready_n <= use_burst;
      burst_ready_n <= !use_burst;
    end
    else if (!bus_out.addr_strobe_n)
    begin
      open_q <= 1'b1;
      cnt <= 1;
    end
    else if (open_q)
    begin
      cnt <= cnt + 1;
      if (cnt >= int'(waits))
      begin
        open_q <= 1'b0;
        ready_n <= use_burst;
        burst_ready_n <= !use_burst;
      end
    end
  end
endmodule : crst_board

// >>> crst_tb.sv
// testbench: start-up paths, bus cycles, hold and async reset
// assumes: crst_pkg, crst_seq, crst_board compiled first
`timescale 1ns/1ns
module testbench;
  logic clock, nrst, reset_in, addr_hold_req, flush_n, hold_req;
  logic fp_fault, parity_fault, ready_n, burst_ready_n, bus_oe, misc_oe;
  logic req_done, running, bur;
  logic [3:0]           unit_fault, waits;
  logic [31:0]          accumulator;
  crst_pkg::crst_req_t  req;
  crst_pkg::crst_bus_t  bus_out;
  crst_pkg::crst_misc_t misc_out;
  int                   n_mismatch, comparisons, k;
  crst_seq #(.TEST_CYCLES(64)) crst_seq_i (.*);
  crst_board crst_board_i (.clock, .bus_out, .waits, .use_burst(bur), .ready_n, .burst_ready_n);
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // reset pulse of 15 clocks, selects only on the last high clock
  task automatic board_reset(input logic ah, input logic fl);
    reset_in = 1'b1;
    repeat (14) @(negedge clock);
    addr_hold_req = ah;
    flush_n = fl;
    @(negedge clock);
    reset_in = 1'b0;
    addr_hold_req = 1'b0;
    flush_n = 1'b1;
    repeat (3) @(negedge clock);
    k = 3;
    while (running !== 1'b1 && k < 700)
    begin
      @(negedge clock);
      k++;
    end
  endtask : board_reset
  task automatic bus_cycle(input logic [31:0] a, input logic [1:0] sz, input logic [3:0] w);
    int n;
    n = 0;
    waits = w;
    bur = w[0];
    req = '{1'b1, a, a[0], sz, w[1], w[1]};
    @(negedge clock);
    while (bus_out.addr_strobe_n !== 1'b0 && n < 9)
    begin
      @(negedge clock);
      n++;
    end
    chk(bus_out.addr === a && bus_out.size === sz, "addr or size");
    chk(bus_out.burst_last_n === !w[1], "last flag");
    n = 0;
    while (req_done !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    chk(n == int'(w) + 2, "cycle length");
    req.valid = 1'b0;
    @(negedge clock);
  endtask : bus_cycle
  task automatic t_start_and_cycles;
    board_reset(1'b0, 1'b1);
    chk(k >= 217 && k <= 224, "normal start delay");
    bus_cycle(32'hC0DE_0010, crst_pkg::SIZE_8, 4'h0);
    bus_cycle(32'hC0DE_0021, crst_pkg::SIZE_16, 4'h1);
    bus_cycle(32'hC0DE_0032, crst_pkg::SIZE_32, 4'h3);
    $display("start and cycles done");
  endtask : t_start_and_cycles
  task automatic t_self_test;
    for (int i = 0; i < 5; i++)
    begin
      unit_fault = (i == 0) ? 4'h0 : 4'h1 << (i - 1);
      board_reset(1'b1, 1'b1);
      chk(k >= 64 + 217, "self test length");
      chk(accumulator === {28'h0000000, unit_fault}, "test result");
    end
    unit_fault = 4'h0;
    reset_in = 1'b1;
    repeat (15) @(negedge clock);
    reset_in = 1'b0;
    addr_hold_req = 1'b1;  // raised after the last high edge, must not count
    flush_n = 1'b0;
    repeat (2) @(negedge clock);
    addr_hold_req = 1'b0;
    flush_n = 1'b1;
    k = 2;
    while (running !== 1'b1 && k < 700)
    begin
      @(negedge clock);
      k++;
    end
    chk(k >= 217 && k <= 224, "late selects ignored");
    $display("self test done");
  endtask : t_self_test
  task automatic t_hold_async_float;
    reset_in = 1'b1;
    hold_req = 1'b1;
    fp_fault = 1'b1;
    parity_fault = 1'b1;
    repeat (6) @(negedge clock);
    chk(misc_out.hold_ack === 1'b1 && bus_oe === 1'b0, "hold in reset");
    chk(misc_out.fp_error_n === 1'b0 && misc_out.parity_check_n === 1'b0, "status out");
    hold_req = 1'b0;
    fp_fault = 1'b0;
    parity_fault = 1'b0;
    board_reset(1'b0, 1'b1);
    #1 nrst = 1'b0;
    #1 chk(running === 1'b0 && bus_out.addr_strobe_n === 1'b1, "async reset");
    @(negedge clock);
    nrst = 1'b1;
    board_reset(1'b1, 1'b0);
    chk(bus_oe === 1'b0 && misc_oe === 1'b0 && running === 1'b0, "float mode");
    reset_in = 1'b1;
    repeat (4) @(negedge clock);
    chk(misc_oe === 1'b1, "float left on reset");
    $display("hold, async and float done");
  endtask : t_hold_async_float
  initial
  begin
    nrst = 1'b0;
    reset_in = 1'b1;
    addr_hold_req = 1'b0;
    flush_n = 1'b1;
    hold_req = 1'b0;
    fp_fault = 1'b0;
    parity_fault = 1'b0;
    unit_fault = 4'h0;
    req = '0;
    waits = 4'h0;
    bur = 1'b0;
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    t_start_and_cycles();
    t_self_test();
    t_hold_async_float();
    give_verdict();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #160000;
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
